// File: rtl/spcp_cfg.svh
// Purpose: register map, field positions and reset values of the serial port
// Assumes: byte-wide registers on a 3-bit register port address
// Notes: definitions only
`ifndef SPCP_CFG_SVH
`define SPCP_CFG_SVH
// register offsets
`define SPCP_OFS_CTRL1 3'h0
`define SPCP_OFS_CTRL2 3'h1
`define SPCP_OFS_BAUD 3'h2
`define SPCP_OFS_STAT 3'h3
`define SPCP_OFS_DATA 3'h4
`define SPCP_OFS_IRQ_STAT 3'h5
`define SPCP_OFS_IRQ_MASK 3'h6
// spi_control_one fields
`define SPCP_C1_RXF_IE 7
`define SPCP_C1_SYS_EN 6
`define SPCP_C1_TXE_IE 5
`define SPCP_C1_ROLE 4
`define SPCP_C1_CLOCK_POLARITY 3
`define SPCP_C1_CLOCK_PHASE 2
`define SPCP_C1_SELECT_OUTPUT_ENABLE 1
`define SPCP_C1_LSBF 0
// spi_control_two fields
`define SPCP_C2_FAULT_EN 4
`define SPCP_C2_DRIVE 3
`define SPCP_C2_WAIT 1
`define SPCP_C2_SWIRE 0
`define SPCP_C2_IMPL 8'h1b
// status register fields
`define SPCP_ST_RXF 7
`define SPCP_ST_TXE 5
`define SPCP_ST_FAULT 4
// baud register implemented bits
`define SPCP_BAUD_IMPL 8'h77
// interrupt status / mask bit positions
`define SPCP_IRQ_RXF 0
`define SPCP_IRQ_FAULT 1
`define SPCP_IRQ_TXE 2
// reset values
`define SPCP_RST_CTRL1 8'h00
`define SPCP_RST_CTRL2 8'h00
`define SPCP_RST_BAUD 8'h00
`define SPCP_RST_MASK 3'h0
// link figures
`define SPCP_LAST_EDGE 4'hf
`define SPCP_DIV_W 11
`endif

// File: rtl/spcp_pkg.sv
// Purpose: shared types of the serial port block
// Assumes: constants live in spcp_cfg.svh
// Notes: types only
package spcp_pkg;
  // master sequencer states
  typedef enum logic [1:0] {
    SPCP_IDLE,
    SPCP_RUN,
    SPCP_TAIL
  } spcp_state_e;
  typedef logic [7:0] spcp_byte_t;
endpackage

// File: rtl/spcp_top.sv
// Purpose: serial peripheral port with control registers and pin muxing
// Assumes: one 100 MHz clock; link pins sampled by three flops
// Notes: output enables are active low; registers on a plain port
// Overview of operation
// - slave uses select pin as low-true select
// - master without fault function releases select pin
// - master fault function: fault input or select output
// - stop modes disable; deep stop resets all but pin synchronisers, read data and transmit buffer
// - light stop freezes state, resumes afterwards
// - receive-full/fault interrupt gated by bit 7
// - clearing enable aborts, flushes, sets transmit empty
// - transmit-empty interrupt gated by bit 5
// - bit 4 picks slave or clock-making master
// - bit 3 inverts clock idle level
// - bit 2 picks first edge mid or start
// - bit 0 picks msb or lsb first
// - slave ignores fault enable and output select
// - single-wire: drive bit steers shared pin direction
// - single-wire uses own-side data pin only
// - wait-stop bit freezes clocks in wait
// - unimplemented control-two bits read zero
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "spcp_cfg.svh"
module spcp_top
  import spcp_pkg::*;
(
  input wire logic clk_i, // 100 MHz clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic [2:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after strobe
  output logic irq_o, // level interrupt
  input wire logic stop_deep_i, // deepest stop modes active
  input wire logic stop_light_i, // light stop mode active
  input wire logic wait_i, // processor in wait mode
  input wire logic sclk_i, // serial_clock_pin level
  output logic sclk_o, // serial_clock_pin drive value
  output logic sclk_oe_n_o, // serial_clock_pin enable, low drives
  input wire logic mosi_i, // master-out pin level
  output logic mosi_o, // master-out pin drive value
  output logic mosi_oe_n_o, // master-out pin enable, low drives
  input wire logic miso_i, // master-in pin level
  output logic miso_o, // master-in pin drive value
  output logic miso_oe_n_o, // master-in pin enable, low drives
  input wire logic ss_n_i, // select pin level
  output logic ss_n_o, // select pin drive value
  output logic ss_n_oe_n_o // select pin enable, low drives
);

  // deep stop powers the block down: same effect as reset, except on pin synchronisers and read data
  logic clr_all; // combined reset
  assign clr_all = !rstn_i || stop_deep_i;

  // input synchronisers: {select, miso, mosi, sclk}
  logic [3:0] pin_raw; // raw pin levels
  logic [3:0] s1_r; // first stage, read by s2 only
  logic [3:0] s2_r; // second stage
  logic [3:0] s3_r; // third stage
  logic [3:0] pin_f_r; // filtered pin levels
  assign pin_raw = {ss_n_i, miso_i, mosi_i, sclk_i};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      // change accepted once stages two and three agree
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          s1_r[g] <= 1'b1;
          s2_r[g] <= 1'b1;
          s3_r[g] <= 1'b1;
          pin_f_r[g] <= 1'b1;
        end else begin
          s1_r[g] <= pin_raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            pin_f_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  logic sck_f, mosi_f, miso_f, ss_n_f; // filtered pins
  assign sck_f = pin_f_r[0];
  assign mosi_f = pin_f_r[1];
  assign miso_f = pin_f_r[2];
  assign ss_n_f = pin_f_r[3];

  // control registers
  spcp_byte_t ctrl1_r; // spi_control_one
  spcp_byte_t ctrl2_r; // spi_control_two
  spcp_byte_t baud_r; // divider setting
  logic [2:0] irq_stat_r; // sticky event bits
  logic [2:0] irq_mask_r; // interrupt mask

  logic rxf_ie, sys_en, txe_ie, master, clock_polarity, clock_phase, select_output_enable, lsbf;
  logic fault_en, drive_en, wait_stop, swire;
  assign rxf_ie = ctrl1_r[`SPCP_C1_RXF_IE];
  assign sys_en = ctrl1_r[`SPCP_C1_SYS_EN];
  assign txe_ie = ctrl1_r[`SPCP_C1_TXE_IE];
  assign master = ctrl1_r[`SPCP_C1_ROLE];
  assign clock_polarity = ctrl1_r[`SPCP_C1_CLOCK_POLARITY];
  assign clock_phase = ctrl1_r[`SPCP_C1_CLOCK_PHASE];
  assign select_output_enable = ctrl1_r[`SPCP_C1_SELECT_OUTPUT_ENABLE];
  assign lsbf = ctrl1_r[`SPCP_C1_LSBF];
  assign fault_en = ctrl2_r[`SPCP_C2_FAULT_EN];
  assign drive_en = ctrl2_r[`SPCP_C2_DRIVE];
  assign wait_stop = ctrl2_r[`SPCP_C2_WAIT];
  assign swire = ctrl2_r[`SPCP_C2_SWIRE];

  // register port decode
  logic wr_c1, wr_c2, wr_bd, wr_dat, wr_ist, wr_imk, rd_st, rd_dat;
  assign wr_c1 = wr_i && (addr_i == `SPCP_OFS_CTRL1);
  assign wr_c2 = wr_i && (addr_i == `SPCP_OFS_CTRL2);
  assign wr_bd = wr_i && (addr_i == `SPCP_OFS_BAUD);
  assign wr_dat = wr_i && (addr_i == `SPCP_OFS_DATA);
  assign wr_ist = wr_i && (addr_i == `SPCP_OFS_IRQ_STAT);
  assign wr_imk = wr_i && (addr_i == `SPCP_OFS_IRQ_MASK);
  assign rd_st = rd_i && (addr_i == `SPCP_OFS_STAT);
  assign rd_dat = rd_i && (addr_i == `SPCP_OFS_DATA);

  // power state: stop modes disable; light stop, and wait with wait-stop set, freeze
  logic halt; // engine frozen this cycle
  logic pins_on; // block owns its pins
  assign halt = stop_light_i || (wait_i && wait_stop);
  assign pins_on = sys_en && !stop_light_i;

  // mode fault: master with select pin as fault input, pulled low
  logic fault_in; // fault detected this cycle
  assign fault_in = sys_en && !halt && master && fault_en && !select_output_enable &&
                    !ss_n_f;

  // spi_control_one; a fault drops the role bit even during a write
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      ctrl1_r <= `SPCP_RST_CTRL1;
    end else begin
      if (wr_c1) begin
        ctrl1_r <= wdata_i;
      end
      if (fault_in) begin
        ctrl1_r[`SPCP_C1_ROLE] <= 1'b0;
      end
    end
  end

  // spi_control_two and divider; unimplemented bits stay zero
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      ctrl2_r <= `SPCP_RST_CTRL2;
      baud_r <= `SPCP_RST_BAUD;
    end else begin
      if (wr_c2) begin
        ctrl2_r <= wdata_i & `SPCP_C2_IMPL;
      end
      if (wr_bd) begin
        baud_r <= wdata_i & `SPCP_BAUD_IMPL;
      end
    end
  end

  // half-bit divider: prescale (1..8) times 2^rate cycles
  logic [`SPCP_DIV_W-1:0] half_cnt; // cycles per clock half
  logic [`SPCP_DIV_W-1:0] div_r; // divider count
  logic tick; // one-cycle half-bit enable
  spcp_state_e st_r; // master sequencer state
  assign half_cnt = ({8'h00, baud_r[6:4]} + 11'h001) << baud_r[2:0];
  assign tick = (st_r != SPCP_IDLE) && !halt &&
                (div_r == half_cnt - 11'h001);

  always_ff @(posedge clk_i) begin
    if (clr_all || st_r == SPCP_IDLE || tick) begin
      div_r <= '0;
    end else if (!halt) begin
      div_r <= div_r + 11'h001;
    end
  end

  // slave clock edge detect on the filtered pin
  logic sck_prev_r; // previous filtered clock
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      sck_prev_r <= 1'b1;
    end else if (!halt) begin
      sck_prev_r <= sck_f;
    end
  end

  // shifter helpers
  function automatic spcp_byte_t shift_in(input spcp_byte_t v,
                                          input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  spcp_byte_t sh_r; // shift register
  spcp_byte_t tx_buf_r; // transmit buffer
  spcp_byte_t rx_buf_r; // receive buffer
  logic tx_full_r; // transmit buffer holds data
  logic rx_full_r; // receive_full_flag
  logic fault_r; // mode_fault_flag
  logic [3:0] edge_r; // clock edge index within byte
  logic samp_r; // last sampled data bit
  logic sclk_r; // master clock level
  logic ss_out_r; // master automatic select level
  logic rxf_arm_r, txe_arm_r, flt_arm_r; // status read seen

  // slave selected only while enabled as slave and select low
  logic slv_sel; // slave participates
  assign slv_sel = sys_en && !master && !ss_n_f;

  logic edge_go; // a clock edge happens now
  logic is_samp; // this edge samples
  logic in_bit; // incoming data bit
  logic last_edge; // sixteenth edge of byte
  spcp_byte_t sh_new; // shifter after this edge
  assign edge_go = !halt && (master ? tick && (st_r == SPCP_RUN) :
                   slv_sel && (sck_f != sck_prev_r));
  assign is_samp = (edge_r[0] == clock_phase);
  assign in_bit = master ? (swire ? mosi_f : miso_f) :
                  (swire ? miso_f : mosi_f);
  assign last_edge = (edge_r == `SPCP_LAST_EDGE);
  assign sh_new = shift_in(sh_r, is_samp ? in_bit : samp_r, lsbf);

  logic byte_done; // byte completes this cycle
  logic m_start; // master loads a byte
  assign byte_done = edge_go && last_edge;
  assign m_start = sys_en && master && !halt && st_r == SPCP_IDLE &&
                   tx_full_r;

  // transfer engine: sequencer, shifter, buffers
  always_ff @(posedge clk_i) begin
    if (clr_all || !sys_en || fault_in) begin
      st_r <= SPCP_IDLE;
      edge_r <= 4'h0;
      sh_r <= '0;
      samp_r <= 1'b0;
      sclk_r <= clock_polarity;
      ss_out_r <= 1'b1;
      tx_full_r <= 1'b0;
      rx_buf_r <= '0;
    end else begin
      if (edge_go) begin
        edge_r <= edge_r + 4'h1;
        if (master) begin
          sclk_r <= !sclk_r;
        end
        if (is_samp) begin
          samp_r <= in_bit;
        end
        // clock_phase 1: the first edge only starts driving the first bit;
        // a sampling edge never moves the data line (hold hazard),
        // the last bit reaches the receive buffer through sh_new
        if (!is_samp && !(edge_r == 4'h0 && clock_phase)) begin
          sh_r <= sh_new;
        end
      end
      if (byte_done) begin
        rx_buf_r <= sh_new;
        if (master) begin
          st_r <= SPCP_TAIL;
        end
      end
      if (!master && !slv_sel) begin
        edge_r <= 4'h0; // deselect restarts the byte
      end
      if (!master && sys_en && !halt && tx_full_r &&
          (!slv_sel || byte_done)) begin
        sh_r <= tx_buf_r; // slave reload between bytes
        tx_full_r <= 1'b0;
      end else if (m_start) begin
        sh_r <= tx_buf_r;
        tx_full_r <= 1'b0;
        st_r <= SPCP_RUN;
        edge_r <= 4'h0;
        ss_out_r <= 1'b0;
      end else if (wr_dat && txe_arm_r && !tx_full_r) begin
        tx_buf_r <= wdata_i;
        tx_full_r <= 1'b1;
      end
      if (st_r == SPCP_TAIL && tick) begin
        st_r <= SPCP_IDLE;
        ss_out_r <= 1'b1;
      end
      if (st_r == SPCP_IDLE) begin
        sclk_r <= clock_polarity;
      end
    end
  end

  // receive_full_flag: set by a finished byte, wins over clear
  always_ff @(posedge clk_i) begin
    if (clr_all || !sys_en) begin
      rx_full_r <= 1'b0;
    end else if (byte_done) begin
      rx_full_r <= 1'b1;
    end else if (rd_dat && rxf_arm_r) begin
      rx_full_r <= 1'b0;
    end
  end

  // mode_fault_flag: cleared by status read then control-one write
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      fault_r <= 1'b0;
    end else if (fault_in) begin
      fault_r <= 1'b1;
    end else if (wr_c1 && flt_arm_r) begin
      fault_r <= 1'b0;
    end
  end

  // status-read arming for the two-step flag clears
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      rxf_arm_r <= 1'b0;
      txe_arm_r <= 1'b0;
      flt_arm_r <= 1'b0;
    end else begin
      if (rd_st) begin
        rxf_arm_r <= rx_full_r;
        txe_arm_r <= !tx_full_r;
        flt_arm_r <= fault_r;
      end else begin
        if (rd_dat) begin
          rxf_arm_r <= 1'b0;
        end
        if (wr_dat) begin
          txe_arm_r <= 1'b0;
        end
        if (wr_c1) begin
          flt_arm_r <= 1'b0;
        end
      end
    end
  end

  // sticky interrupt status: enabled flags set, write one clears
  logic [2:0] irq_ev; // events this cycle
  assign irq_ev[`SPCP_IRQ_RXF] = rxf_ie && rx_full_r;
  assign irq_ev[`SPCP_IRQ_FAULT] = rxf_ie && fault_r;
  assign irq_ev[`SPCP_IRQ_TXE] = txe_ie && !tx_full_r;

  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= `SPCP_RST_MASK;
    end else begin
      // set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~(wr_ist ? wdata_i[2:0] : 3'h0)) |
                    irq_ev;
      if (wr_imk) begin
        irq_mask_r <= wdata_i[2:0];
      end
    end
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      case (addr_i)
        `SPCP_OFS_CTRL1: rdata_o <= ctrl1_r;
        `SPCP_OFS_CTRL2: rdata_o <= ctrl2_r & `SPCP_C2_IMPL;
        `SPCP_OFS_BAUD: rdata_o <= baud_r;
        `SPCP_OFS_STAT: begin
          rdata_o <= 8'h00;
          rdata_o[`SPCP_ST_RXF] <= rx_full_r;
          rdata_o[`SPCP_ST_TXE] <= !tx_full_r;
          rdata_o[`SPCP_ST_FAULT] <= fault_r;
        end
        `SPCP_OFS_DATA: rdata_o <= rx_buf_r;
        `SPCP_OFS_IRQ_STAT: rdata_o <= {5'h00, irq_stat_r};
        `SPCP_OFS_IRQ_MASK: rdata_o <= {5'h00, irq_mask_r};
        default: rdata_o <= 8'h00; // unmapped reads zero
      endcase
    end
  end

  // pin muxing; a released pin goes back to port control
  logic dbit; // outgoing data bit
  assign dbit = lsbf ? sh_r[0] : sh_r[7];
  assign sclk_o = sclk_r;
  assign mosi_o = dbit;
  assign miso_o = dbit;
  assign ss_n_o = ss_out_r;
  assign sclk_oe_n_o = !(pins_on && master);

  // master data out pin, or shared pin in single-wire mode
  assign mosi_oe_n_o = !(pins_on && master &&
                         (!swire || drive_en));

  // slave data out pin, driven only while selected
  assign miso_oe_n_o = !(pins_on && slv_sel &&
                         (!swire || drive_en));

  // select output only as master with fault function and select_output_enable
  assign ss_n_oe_n_o = !(pins_on && master && fault_en &&
                         select_output_enable);

endmodule

// File: verif/spcp_top_monitor.sv
// Purpose: port-level checks of the serial port block
// Assumes: one clock domain, synchronous low-true reset
// Notes: attached by bind below
`timescale 1ns/1ps
`include "spcp_cfg.svh"
module spcp_top_monitor (
  input wire logic clk_i, // block clock
  input wire logic rstn_i, // reset, low active
  input wire logic [2:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] rdata_o, // read data
  input wire logic irq_o, // interrupt level
  input wire logic stop_deep_i, // deep stop
  input wire logic stop_light_i, // light stop
  input wire logic ss_n_i, // select pin level
  input wire logic sclk_o, // clock drive value
  input wire logic sclk_oe_n_o, // clock enable, low drives
  input wire logic mosi_oe_n_o, // master-out enable
  input wire logic miso_oe_n_o, // master-in enable
  input wire logic ss_n_o, // automatic select
  input wire logic ss_n_oe_n_o // select enable
);
  logic [4:0] edge_cnt_r; // clock edges inside one select
  logic sclk_q_r; // clock level one cycle ago
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // count clock toggles while automatic select is low
  always_ff @(posedge clk_i) begin
    if (!rstn_i || ss_n_o) begin
      edge_cnt_r <= 5'h00;
    end else if (sclk_o != sclk_q_r) begin
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end
  end
  // previous clock level, for edge detection
  always_ff @(posedge clk_i) begin
    sclk_q_r <= sclk_o;
  end
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside read");
  ctrl_two_rsv_a: assert property (
    rd_i && addr_i == `SPCP_OFS_CTRL2 |=> (rdata_o & 8'he4) == 8'h00)
    else $error("unimplemented control two bits read one");
  unmapped_rd_a: assert property (
    rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  slave_release_a: assert property (ss_n_i [*5] |-> miso_oe_n_o)
    else $error("slave drives data while not selected");
  select_master_a: assert property (!ss_n_oe_n_o |-> !sclk_oe_n_o)
    else $error("select driven outside master role");
  master_miso_a: assert property (!sclk_oe_n_o |-> miso_oe_n_o)
    else $error("master drives slave data pin");
  irq_mask_a: assert property (
    wr_i && addr_i == `SPCP_OFS_IRQ_MASK && wdata_i[2:0] == 3'h0
    |=> !irq_o) else $error("interrupt with all masked");
  deep_stop_a: assert property (stop_deep_i |=> sclk_oe_n_o &&
    mosi_oe_n_o && miso_oe_n_o && ss_n_oe_n_o && !irq_o)
    else $error("pins or interrupt active after deep stop");
  light_stop_a: assert property (stop_light_i [*2] |->
    sclk_oe_n_o && mosi_oe_n_o && miso_oe_n_o && ss_n_oe_n_o)
    else $error("pins driven in light stop");
  disable_a: assert property (
    wr_i && addr_i == `SPCP_OFS_CTRL1 && !wdata_i[6] |=> sclk_oe_n_o &&
    mosi_oe_n_o && miso_oe_n_o && ss_n_oe_n_o)
    else $error("pins driven after disable");
  edge_count_a: assert property (
    $rose(ss_n_o) && !sclk_oe_n_o |-> edge_cnt_r == 5'h10)
    else $error("byte not sixteen clock edges");
endmodule
bind spcp_top spcp_top_monitor mon_u (.*);

// File: verif/spcp_slave_model.sv
// Purpose: behavioural far-side slave for master transfers
// Assumes: mode inputs stable while selected
// Notes: released data line shows the inverse of its last value
`timescale 1ns/1ps
module spcp_slave_model (
  input wire logic sclk_i, // link clock level
  input wire logic ss_n_i, // select, low active
  input wire logic mosi_i, // data from master
  input wire logic clock_polarity_i, // clock idle level
  input wire logic clock_phase_i, // clock phase
  input wire logic lsbf_i, // low bit first
  input wire logic [7:0] tx_i, // byte to return
  output logic miso_o, // data to master
  output logic [7:0] rx_o // byte captured
);
  logic [7:0] sh_r; // outgoing shifter
  initial miso_o = 1'b0;
  // present next bit and advance, order by lsbf
  task automatic put;
    miso_o = lsbf_i ? sh_r[0] : sh_r[7];
    sh_r = lsbf_i ? sh_r >> 1 : sh_r << 1;
  endtask
  // phase 0 shows first bit at select fall
  always @(negedge ss_n_i) begin
    sh_r = tx_i;
    if (!clock_phase_i) put();
  end
  // release: no stale value left on the line
  always @(posedge ss_n_i) miso_o = ~miso_o;
  // leading edge is clock xor polarity rising
  always @(sclk_i) begin
    if (ss_n_i === 1'b0) begin
      if ((sclk_i ^ clock_polarity_i) != clock_phase_i) begin
        rx_o = lsbf_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
      end else begin
        put();
      end
    end
  end
endmodule

// File: verif/spcp_top_tb.sv
// Purpose: self-checking bench of the serial port block
// Assumes: half period of eight cycles for master bytes
// Notes: queue model holds bytes the slave model returns
`timescale 1ns/1ps
`include "spcp_cfg.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module spcp_top_tb;
  import spcp_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, rx_pm, tx_pm = 8'h00, d;
  logic stop_deep_i = 1'b0, stop_light_i = 1'b0, wait_i = 1'b0;
  logic tb_sclk = 1'b0, tb_ss = 1'b1, tb_mosi = 1'b0, pm_miso;
  logic clock_polarity = 1'b0, clock_phase = 1'b0, lsbf = 1'b0;
  logic irq_o, sclk_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o;
  logic miso_o, miso_oe_n_o, ss_n_o, ss_n_oe_n_o;
  // pin levels from the device's enables; released select follows tb_ss
  wire sclk_i = sclk_oe_n_o ? tb_sclk : sclk_o;
  wire mosi_i = mosi_oe_n_o ? tb_mosi : mosi_o;
  wire miso_i = miso_oe_n_o ? pm_miso : miso_o;
  wire ss_n_i = ss_n_oe_n_o ? tb_ss : ss_n_o;
  int failures = 0, n_tests = 0, m;
  spcp_byte_t exp_q[$]; // bytes the device must receive
  always #5 clk_i = ~clk_i;
  spcp_top dut_u (.*);
  spcp_slave_model pm_u (.sclk_i(sclk_i), .ss_n_i(ss_n_i),
    .mosi_i(mosi_i), .clock_polarity_i(clock_polarity), .clock_phase_i(clock_phase), .lsbf_i(lsbf),
    .tx_i(tx_pm), .miso_o(pm_miso), .rx_o(rx_pm));
  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // data write counts only after a status read
  task automatic put_tx(input logic [7:0] v);
    rd(`SPCP_OFS_STAT, d);
    wr(`SPCP_OFS_DATA, v);
  endtask
  // bounded poll for receive full
  task automatic wait_rxf();
    for (int k = 0; k < 300; k++) begin
      rd(`SPCP_OFS_STAT, d);
      if (d[`SPCP_ST_RXF] === 1'b1) return;
    end
    failures++;
    stop_test();
  endtask
  // one master byte with automatic select; keep leaves it unread
  task automatic xfer_m(input int md, input bit keep);
    logic [7:0] v, x;
    v = $urandom;
    tx_pm = $urandom;
    {clock_polarity, clock_phase, lsbf} = md[2:0];
    wr(`SPCP_OFS_CTRL1, 8'h52 | {4'h0, clock_polarity, clock_phase, 1'b0, lsbf});
    wait_i <= md[0];
    exp_q.push_back(tx_pm);
    put_tx(v);
    wait_rxf();
    `CHK("wire byte", v, rx_pm);
    `CHK("clock idle", clock_polarity, sclk_o);
    if (!keep) begin
      rd(`SPCP_OFS_DATA, d);
      x = exp_q.pop_front();
      `CHK("rx byte", x, d);
    end
    $display("master byte mode %0d done", md);
  endtask
  // bench acts as master, 125 ns link clock, mode 0
  task automatic xfer_s();
    logic [7:0] v, b, got;
    v = $urandom;
    b = $urandom;
    got = 8'h00;
    wr(`SPCP_OFS_CTRL1, 8'h42);
    wr(`SPCP_OFS_CTRL2, 8'h18);
    `CHK("slave select oe", 1'b1, ss_n_oe_n_o);
    put_tx(v);
    tb_ss <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tb_mosi <= b[i];
      #62.5 got = {got[6:0], miso_i};
      tb_sclk <= 1'b1;
      #62.5 tb_sclk <= 1'b0;
    end
    #62.5 tb_ss <= 1'b1;
    wait_rxf();
    rd(`SPCP_OFS_DATA, d);
    `CHK("slave rx", b, d);
    `CHK("slave tx", v, got);
    $display("slave byte done");
  endtask
  initial begin
    void'($urandom(77719));
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`SPCP_OFS_CTRL1, d);
    `CHK("ctrl1 reset", 8'h00, d);
    wr(`SPCP_OFS_CTRL2, 8'hff);
    rd(`SPCP_OFS_CTRL2, d);
    `CHK("ctrl2 mask", 8'h1b, d);
    rd(3'h7, d);
    `CHK("unmapped", 8'h00, d);
    wr(`SPCP_OFS_CTRL2, 8'h01);
    wr(`SPCP_OFS_CTRL1, 8'h50);
    `CHK("shared in", 1'b1, mosi_oe_n_o);
    wr(`SPCP_OFS_CTRL2, 8'h09);
    `CHK("shared out", 1'b0, mosi_oe_n_o);
    `CHK("slave pin idle", 1'b1, miso_oe_n_o);
    $display("register test done");
    wr(`SPCP_OFS_CTRL2, 8'h00);
    wr(`SPCP_OFS_CTRL1, 8'h52);
    @(posedge clk_i);
    tb_ss <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(`SPCP_OFS_STAT, d);
    `CHK("no fault", 1'b0, d[`SPCP_ST_FAULT]);
    `CHK("select free", 1'b1, ss_n_oe_n_o);
    wr(`SPCP_OFS_CTRL1, 8'hd0);
    wr(`SPCP_OFS_CTRL2, 8'h10);
    repeat (6) @(posedge clk_i);
    rd(`SPCP_OFS_STAT, d);
    `CHK("fault flag", 1'b1, d[`SPCP_ST_FAULT]);
    rd(`SPCP_OFS_CTRL1, d);
    `CHK("role dropped", 1'b0, d[`SPCP_C1_ROLE]);
    rd(`SPCP_OFS_IRQ_STAT, d);
    `CHK("fault sticky", 1'b1, d[`SPCP_IRQ_FAULT]);
    `CHK("irq masked", 1'b0, irq_o);
    wr(`SPCP_OFS_IRQ_MASK, 8'h02);
    `CHK("irq fault", 1'b1, irq_o);
    @(posedge clk_i);
    tb_ss <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(`SPCP_OFS_STAT, d);
    wr(`SPCP_OFS_CTRL1, 8'h52);
    wr(`SPCP_OFS_IRQ_STAT, 8'h02);
    `CHK("irq cleared", 1'b0, irq_o);
    `CHK("select out", 1'b0, ss_n_oe_n_o);
    wr(`SPCP_OFS_CTRL1, 8'h72);
    wr(`SPCP_OFS_IRQ_MASK, 8'h04);
    `CHK("irq tx empty", 1'b1, irq_o);
    wr(`SPCP_OFS_CTRL1, 8'h52);
    wr(`SPCP_OFS_IRQ_STAT, 8'h04);
    `CHK("irq tx clear", 1'b0, irq_o);
    wr(`SPCP_OFS_IRQ_MASK, 8'h00);
    $display("fault and interrupt test done");
    wr(`SPCP_OFS_BAUD, 8'h12);
    for (m = 0; m < 8; m++) xfer_m(m, m == 7);
    wr(`SPCP_OFS_CTRL1, 8'h1f);
    rd(`SPCP_OFS_STAT, d);
    `CHK("disable flush", 8'h20, d);
    void'(exp_q.pop_front());
    xfer_s();
    wr(`SPCP_OFS_CTRL1, 8'h5c);
    @(posedge clk_i);
    stop_light_i <= 1'b1;
    rd(`SPCP_OFS_CTRL1, d);
    `CHK("light keeps", 8'h5c, d);
    @(posedge clk_i);
    stop_light_i <= 1'b0;
    xfer_m(0, 0);
    // wait with clock stop set: no byte may start until wait ends
    repeat (20) @(posedge clk_i);
    wr(`SPCP_OFS_CTRL2, 8'h12);
    @(posedge clk_i);
    wait_i <= 1'b1;
    put_tx(8'h3c);
    repeat (40) @(posedge clk_i);
    `CHK("wait frozen", 1'b1, ss_n_o);
    wait_i <= 1'b0;
    wait_rxf();
    `CHK("wait resume", 8'h3c, rx_pm);
    @(posedge clk_i);
    stop_deep_i <= 1'b1;
    @(posedge clk_i);
    stop_deep_i <= 1'b0;
    rd(`SPCP_OFS_CTRL1, d);
    `CHK("deep resets", 8'h00, d);
    $display("stop test done");
    stop_test();
  end
endmodule
